// *** pkg/lcs_pkg.sv ***
// Package for the link codec status and reset block: register map, field layout, resets.
// Assumes a 32-bit APB register bus and a single clock domain.
`default_nettype none
package lcs_pkg;
	// Register byte offsets
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_CONFIG = 12'h004;
	localparam logic [11:0] ADDR_VC_STATUS = 12'h008;
	localparam logic [11:0] ADDR_LINK_STATUS = 12'h00c;
	localparam logic [11:0] ADDR_RETRY_COUNT = 12'h010;
	localparam logic [11:0] ADDR_LANE_STATUS = 12'h014;
	localparam logic [11:0] ADDR_SEED = 12'h018;
	localparam logic [11:0] ADDR_IDLE_LIMIT = 12'h01c;
	localparam logic [11:0] ADDR_LANE_CTRL = 12'h020;
	// Control register bits (write one, self clearing)
	localparam int CTRL_COLD_BIT = 0;
	localparam int CTRL_WARM_BIT = 1;
	// Config register fields
	localparam int CFG_REQ_LANES_LSB = 0;
	localparam int CFG_CAP_LSB = 8;
	// Link status bit positions
	localparam int LS_BROADCAST_MISSED = 0;
	localparam int LS_BC_SEQ_ERR = 1;
	localparam int LS_CRC16_ERR = 2;
	localparam int LS_CRC8_SEQ_ERR = 3;
	localparam int LS_RETRY_EMPTY = 4;
	localparam int LS_BIT_SYNC = 5;
	// Lane status: eight bits per lane
	localparam int LN_ACTIVE = 0;
	localparam int LN_SIGNAL_LOST = 1;
	localparam int LN_RX_ERR = 2;
	localparam int LN_RX_ERR_OVF = 3;
	localparam int LN_STANDBY = 4;
	localparam int LN_TIMEOUT = 5;
	localparam int LN_LOS_WORD = 6;
	localparam int LN_FLUSH = 7;
	// Reset values
	localparam logic [31:0] SEED_RESET = 32'hffffffff;
	localparam logic [7:0] REQ_LANES_RESET = 8'h01;
	localparam logic [7:0] CAP_RESET = 8'h00;
	localparam logic [31:0] IDLE_LIMIT_RESET = 32'h00030d40; // 1 ms at 200 MHz
	localparam logic [31:0] RETRY_RESET = 32'h00000000;
	// Per-lane event pulses from the lane layer
	typedef struct packed {
		logic active;
		logic signal_lost;
		logic receive_error;
		logic rx_err_overflow;
		logic standby_word;
		logic timeout;
		logic loss_of_signal_word;
		logic remote_flush;
		logic rx_inverted;
	} lcs_lane_ev_t;
	// Link-wide inputs
	typedef struct packed {
		logic bc_valid;
		logic [7:0] bc_seq;
		logic crc16_err;
		logic crc8_err;
		logic frame_seq_err;
		logic retry_empty;
		logic retry_event;
		logic bit_sync;
	} lcs_link_ev_t;
	// Reset effects handed to the layers
	typedef struct packed {
		logic flush_vcb;
		logic clear_fct;
		logic clear_credits;
		logic load_space;
		logic clear_seq;
		logic flush_retry;
		logic clear_lane_numbers;
		logic pll_reset;
	} lcs_reset_fx_t;
endpackage
`default_nettype wire

// *** rtl/lcs_status_bank.sv ***
// Status and reset-effect register bank of a multi-layer serial link codec.
// Assumes APB master on pclk; event inputs are synchronous to pclk.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lcs_status_bank #(
	parameter int NUM_VC = 8,
	parameter int NUM_LANES = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_VC-1:0] credit_at_min,
	input wire logic [NUM_VC-1:0] credit_at_max,
	input wire logic [NUM_VC-1:0] far_has_space,
	input wire logic [NUM_VC-1:0] input_full_write,
	input wire lcs_pkg::lcs_link_ev_t link_ev,
	input wire lcs_pkg::lcs_lane_ev_t [NUM_LANES-1:0] lane_ev,
	output lcs_pkg::lcs_reset_fx_t reset_fx,
	output logic [31:0] scrambler_seed,
	output logic [7:0] required_lanes,
	output logic [7:0] lane_caps,
	output logic [NUM_LANES-1:0] rx_invert,
	output logic [31:0] idle_limit
);
	// Each buffer flag kind owns one status byte, so more than eight buffers cannot be shown
	if (NUM_VC < 1 || NUM_VC > 8) begin : g_bad_vc
		$error("NUM_VC must be 1..8");
	end
	if (NUM_LANES < 1 || NUM_LANES > 4) begin : g_bad_lanes
		$error("NUM_LANES must be 1..4");
	end

	logic wr_en;
	logic rd_en;
	logic cold_pulse;
	logic warm_pulse;
	logic [NUM_VC-1:0] overuse;
	logic [NUM_VC-1:0] underuse;
	logic [NUM_VC-1:0] overflow;
	logic [NUM_VC-1:0] has_credit;
	logic [5:0] link_flags;
	logic [31:0] retry_count;
	logic [8*NUM_LANES-1:0] lane_flags;
	logic [NUM_LANES-1:0] rx_pol_flag;
	logic [7:0] last_seq;
	logic seq_seen;
	logic [31:0] idle_cnt [NUM_VC];
	logic [NUM_LANES-1:0] any_flush;
	logic [7:0] seq_delta;
	logic [31:0] vc_word;

	// Accesses complete in the first access cycle; no wait states
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign cold_pulse = wr_en && paddr == lcs_pkg::ADDR_CONTROL && pwdata[lcs_pkg::CTRL_COLD_BIT];
	assign warm_pulse = wr_en && paddr == lcs_pkg::ADDR_CONTROL && pwdata[lcs_pkg::CTRL_WARM_BIT];
	assign seq_delta = link_ev.bc_seq - last_seq;

	// Fixed byte per flag kind, so the read layout does not move with NUM_VC
	always_comb begin
		vc_word = '0;
		vc_word[0 +: NUM_VC] = overuse;
		vc_word[8 +: NUM_VC] = overflow;
		vc_word[16 +: NUM_VC] = underuse;
		vc_word[24 +: NUM_VC] = has_credit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr > lcs_pkg::ADDR_LANE_CTRL;
		end
	end

	// Configuration registers; reset of all but idle_limit is a cold-reset effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scrambler_seed <= lcs_pkg::SEED_RESET;
			required_lanes <= lcs_pkg::REQ_LANES_RESET;
			lane_caps <= lcs_pkg::CAP_RESET;
			idle_limit <= lcs_pkg::IDLE_LIMIT_RESET;
		end else if (cold_pulse) begin
			scrambler_seed <= lcs_pkg::SEED_RESET;
			required_lanes <= lcs_pkg::REQ_LANES_RESET;
			lane_caps <= lcs_pkg::CAP_RESET;
		end else if (wr_en && pready) begin
			case (paddr)
				lcs_pkg::ADDR_CONFIG: begin
					required_lanes <= pwdata[lcs_pkg::CFG_REQ_LANES_LSB +: 8];
					lane_caps <= pwdata[lcs_pkg::CFG_CAP_LSB +: 8];
				end
				lcs_pkg::ADDR_SEED: scrambler_seed <= pwdata;
				lcs_pkg::ADDR_IDLE_LIMIT: idle_limit <= pwdata;
				default: ;
			endcase
		end
	end

	// Receiver inversion: software sets it, both resets turn it off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_invert <= '0;
		end else if (cold_pulse || warm_pulse) begin
			rx_invert <= '0;
		end else if (wr_en && pready && paddr == lcs_pkg::ADDR_LANE_CTRL) begin
			rx_invert <= pwdata[NUM_LANES-1:0];
		end
	end

	// Reset effects as one-cycle pulses to the layers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_fx <= '0;
		end else begin
			reset_fx.flush_vcb <= cold_pulse;
			reset_fx.clear_fct <= cold_pulse;
			reset_fx.clear_credits <= cold_pulse;
			reset_fx.load_space <= cold_pulse;
			reset_fx.clear_seq <= cold_pulse;
			reset_fx.flush_retry <= cold_pulse;
			reset_fx.clear_lane_numbers <= cold_pulse || warm_pulse;
			reset_fx.pll_reset <= cold_pulse || warm_pulse;
		end
	end

	// Per-buffer bandwidth and overflow flags; set wins over clear
	generate
		for (genvar v = 0; v < NUM_VC; v++) begin : g_vc
			logic clr;
			assign clr = wr_en && pready && paddr == lcs_pkg::ADDR_VC_STATUS;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					idle_cnt[v] <= '0;
				end else if (!credit_at_max[v] || cold_pulse) begin
					idle_cnt[v] <= '0;
				end else if (idle_cnt[v] < idle_limit) begin
					// Parks at the limit; a limit lowered mid-count still fires at once
					idle_cnt[v] <= idle_cnt[v] + 32'h00000001;
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					overuse[v] <= 1'b0;
					underuse[v] <= 1'b0;
					overflow[v] <= 1'b0;
					has_credit[v] <= 1'b0;
				end else begin
					has_credit[v] <= far_has_space[v];
					if (credit_at_min[v]) overuse[v] <= 1'b1;
					else if (clr && pwdata[v]) overuse[v] <= 1'b0;
					if (credit_at_max[v] && idle_cnt[v] >= idle_limit) underuse[v] <= 1'b1;
					else if (clr && pwdata[16+v]) underuse[v] <= 1'b0;
					if (input_full_write[v]) overflow[v] <= 1'b1;
					else if (clr && pwdata[8+v]) overflow[v] <= 1'b0;
				end
			end
			overuse_set_a: assert property (@(posedge pclk) disable iff (!presetn)
				credit_at_min[v] |=> overuse[v]) else $error("overuse flag not set");
			underuse_set_a: assert property (@(posedge pclk) disable iff (!presetn)
				credit_at_max[v] && idle_cnt[v] >= idle_limit |=> underuse[v])
				else $error("underuse flag not set");
			idle_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
				!credit_at_max[v] |=> idle_cnt[v] == 32'h00000000) else $error("idle count kept");
			has_credit_a: assert property (@(posedge pclk) disable iff (!presetn)
				1'b1 |=> has_credit[v] == $past(far_has_space[v])) else $error("credit flag lags");
			overflow_set_a: assert property (@(posedge pclk) disable iff (!presetn)
				input_full_write[v] |=> overflow[v]) else $error("overflow flag not set");
			overuse_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
				overuse[v] && !(clr && pwdata[v]) |=> overuse[v]) else $error("overuse flag lost");
		end
	endgenerate

	// Broadcast sequence tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_seq <= '0;
			seq_seen <= 1'b0;
		end else if (cold_pulse) begin
			last_seq <= '0;
			seq_seen <= 1'b0;
		end else if (link_ev.bc_valid) begin
			last_seq <= link_ev.bc_seq;
			seq_seen <= 1'b1;
		end
	end

	// Link-wide flags; retry empty follows its input, for the others writing a one clears and a simultaneous event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_flags <= '0;
		end else begin
			if (link_ev.bc_valid && seq_seen && seq_delta == 8'h02)
				link_flags[lcs_pkg::LS_BROADCAST_MISSED] <= 1'b1;
			else if (wr_en && pready && paddr == lcs_pkg::ADDR_LINK_STATUS && pwdata[0])
				link_flags[lcs_pkg::LS_BROADCAST_MISSED] <= 1'b0;
			if (link_ev.bc_valid && seq_seen && seq_delta != 8'h01 && seq_delta != 8'h02)
				link_flags[lcs_pkg::LS_BC_SEQ_ERR] <= 1'b1;
			else if (wr_en && pready && paddr == lcs_pkg::ADDR_LINK_STATUS && pwdata[1])
				link_flags[lcs_pkg::LS_BC_SEQ_ERR] <= 1'b0;
			if (link_ev.crc16_err)
				link_flags[lcs_pkg::LS_CRC16_ERR] <= 1'b1;
			else if (wr_en && pready && paddr == lcs_pkg::ADDR_LINK_STATUS && pwdata[2])
				link_flags[lcs_pkg::LS_CRC16_ERR] <= 1'b0;
			if (link_ev.crc8_err || link_ev.frame_seq_err)
				link_flags[lcs_pkg::LS_CRC8_SEQ_ERR] <= 1'b1;
			else if (wr_en && pready && paddr == lcs_pkg::ADDR_LINK_STATUS && pwdata[3])
				link_flags[lcs_pkg::LS_CRC8_SEQ_ERR] <= 1'b0;
			link_flags[lcs_pkg::LS_RETRY_EMPTY] <= link_ev.retry_empty;
			if (link_ev.bit_sync)
				link_flags[lcs_pkg::LS_BIT_SYNC] <= 1'b1;
			else if (wr_en && pready && paddr == lcs_pkg::ADDR_LINK_STATUS && pwdata[5])
				link_flags[lcs_pkg::LS_BIT_SYNC] <= 1'b0;
		end
	end

	// Retry count: a reset or flush in the same cycle as an event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_count <= lcs_pkg::RETRY_RESET;
		end else if (cold_pulse || warm_pulse || |any_flush) begin
			retry_count <= lcs_pkg::RETRY_RESET;
		end else if (link_ev.retry_event) begin
			retry_count <= retry_count + 32'h00000001;
		end
	end

	// Per-lane flags; only active-state errors count
	generate
		for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
			logic clr;
			logic [7:0] set;
			assign clr = wr_en && pready && paddr == lcs_pkg::ADDR_LANE_STATUS;
			assign any_flush[l] = lane_ev[l].remote_flush;
			assign set = {lane_ev[l].remote_flush,
				lane_ev[l].loss_of_signal_word,
				lane_ev[l].timeout,
				lane_ev[l].standby_word,
				lane_ev[l].rx_err_overflow && lane_ev[l].active,
				lane_ev[l].receive_error && lane_ev[l].active,
				lane_ev[l].signal_lost && lane_ev[l].active,
				1'b0};
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					lane_flags[8*l +: 8] <= '0;
					rx_pol_flag[l] <= 1'b0;
				end else begin
					lane_flags[8*l+lcs_pkg::LN_ACTIVE] <= lane_ev[l].active;
					for (int b = 1; b < 8; b++) begin
						if (set[b]) lane_flags[8*l+b] <= 1'b1;
						else if (clr && pwdata[8*l+b]) lane_flags[8*l+b] <= 1'b0;
					end
					if (lane_ev[l].rx_inverted) rx_pol_flag[l] <= 1'b1;
					else if (wr_en && pready && paddr == lcs_pkg::ADDR_LANE_CTRL &&
						pwdata[8+l]) rx_pol_flag[l] <= 1'b0;
				end
			end
			lane_active_a: assert property (@(posedge pclk) disable iff (!presetn)
				1'b1 |=> lane_flags[8*l+lcs_pkg::LN_ACTIVE] == $past(lane_ev[l].active))
				else $error("lane active wrong");
			sig_lost_a: assert property (@(posedge pclk) disable iff (!presetn)
				lane_ev[l].signal_lost && !lane_ev[l].active &&
				!lane_flags[8*l+lcs_pkg::LN_SIGNAL_LOST] |=> !lane_flags[8*l+lcs_pkg::LN_SIGNAL_LOST])
				else $error("signal lost outside active");
			rx_err_a: assert property (@(posedge pclk) disable iff (!presetn)
				lane_ev[l].receive_error && lane_ev[l].active |=> lane_flags[8*l+lcs_pkg::LN_RX_ERR])
				else $error("receive error flag not set");
			rx_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
				lane_ev[l].rx_err_overflow && lane_ev[l].active
				|=> lane_flags[8*l+lcs_pkg::LN_RX_ERR_OVF]) else $error("error overflow flag not set");
			far_standby_a: assert property (@(posedge pclk) disable iff (!presetn)
				lane_ev[l].standby_word |=> lane_flags[8*l+lcs_pkg::LN_STANDBY])
				else $error("standby flag not set");
			far_los_a: assert property (@(posedge pclk) disable iff (!presetn)
				lane_ev[l].loss_of_signal_word |=> lane_flags[8*l+lcs_pkg::LN_LOS_WORD])
				else $error("loss word flag not set");
			far_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
				lane_ev[l].remote_flush |=> lane_flags[8*l+lcs_pkg::LN_FLUSH])
				else $error("remote flush flag not set");
			init_timeout_a: assert property (@(posedge pclk) disable iff (!presetn)
				lane_ev[l].timeout |=> lane_flags[8*l+lcs_pkg::LN_TIMEOUT])
				else $error("timeout flag not set");
			rx_polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
				lane_ev[l].rx_inverted |=> rx_pol_flag[l]) else $error("polarity flag not set");
		end
	endgenerate

	// Read data registered at the setup cycle, valid with pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				lcs_pkg::ADDR_CONFIG: prdata <= {16'h0000, lane_caps, required_lanes};
				lcs_pkg::ADDR_VC_STATUS: prdata <= vc_word;
				lcs_pkg::ADDR_LINK_STATUS: prdata <= {26'h0000000, link_flags};
				lcs_pkg::ADDR_RETRY_COUNT: prdata <= retry_count;
				lcs_pkg::ADDR_LANE_STATUS: prdata <= 32'(lane_flags);
				lcs_pkg::ADDR_SEED: prdata <= scrambler_seed;
				lcs_pkg::ADDR_IDLE_LIMIT: prdata <= idle_limit;
				lcs_pkg::ADDR_LANE_CTRL: prdata <= {16'h0000, 8'(rx_pol_flag), 8'(rx_invert)};
				default: prdata <= '0;
			endcase
		end
	end

	crc16_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_ev.crc16_err |=> link_flags[lcs_pkg::LS_CRC16_ERR]) else $error("crc16 flag not set");
	short_check_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_ev.crc8_err || link_ev.frame_seq_err |=> link_flags[lcs_pkg::LS_CRC8_SEQ_ERR])
		else $error("short check flag not set");
	retry_empty_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> link_flags[lcs_pkg::LS_RETRY_EMPTY] == $past(link_ev.retry_empty))
		else $error("retry empty status lags");
	bit_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_ev.bit_sync |=> link_flags[lcs_pkg::LS_BIT_SYNC]) else $error("bit sync flag not set");
	retry_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_ev.retry_event && !cold_pulse && !warm_pulse && !(|any_flush)
		|=> retry_count == $past(retry_count) + 32'h00000001) else $error("retry count no step");
	retry_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cold_pulse || warm_pulse || |any_flush) |=> retry_count == '0) else $error("retry not cleared");
	broadcast_missed_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_ev.bc_valid && seq_seen && seq_delta == 8'h02
		|=> link_flags[lcs_pkg::LS_BROADCAST_MISSED] && (!link_flags[lcs_pkg::LS_BC_SEQ_ERR] ||
		$past(link_flags[lcs_pkg::LS_BC_SEQ_ERR]))) else $error("broadcast missed wrong");
	seq_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_ev.bc_valid && seq_seen && seq_delta != 8'h01 && seq_delta != 8'h02
		|=> link_flags[lcs_pkg::LS_BC_SEQ_ERR]) else $error("sequence error not set");
	first_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
		cold_pulse |=> !seq_seen) else $error("first value not exempt");
	first_exempt_a: assert property (@(posedge pclk) disable iff (!presetn)
		link_ev.bc_valid && !seq_seen && !link_flags[lcs_pkg::LS_BC_SEQ_ERR]
		|=> !link_flags[lcs_pkg::LS_BC_SEQ_ERR]) else $error("first value flagged");
	cold_seed_a: assert property (@(posedge pclk) disable iff (!presetn)
		cold_pulse |=> scrambler_seed == lcs_pkg::SEED_RESET && required_lanes == 8'h01)
		else $error("cold reset seed wrong");
	warm_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		warm_pulse && !cold_pulse |=> $stable(scrambler_seed) && rx_invert == '0 &&
		reset_fx.pll_reset && !reset_fx.flush_vcb) else $error("warm reset wrong");
	cold_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
		cold_pulse |=> reset_fx.flush_vcb && reset_fx.load_space ##1 !reset_fx.flush_vcb)
		else $error("cold flush pulse wrong");
endmodule // lcs_status_bank
`default_nettype wire

// *** test/lcs_status_bank_bench.sv ***
// Self-checking bench for the link codec status and reset register bank.
// Assumes event inputs are one-cycle pulses on pclk; APB accesses wait up to 50 cycles for pready.
`timescale 1ns/1ps
`default_nettype none
module lcs_status_bank_bench;
	localparam int NV = 8;
	localparam int NL = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [NV-1:0] credit_at_min = '0;
	logic [NV-1:0] credit_at_max = '0;
	logic [NV-1:0] far_has_space = '0;
	logic [NV-1:0] input_full_write = '0;
	lcs_pkg::lcs_link_ev_t link_ev = '0;
	lcs_pkg::lcs_lane_ev_t [NL-1:0] lane_ev = '0;
	lcs_pkg::lcs_reset_fx_t reset_fx;
	logic [31:0] scrambler_seed;
	logic [7:0] required_lanes;
	logic [7:0] lane_caps;
	logic [NL-1:0] rx_invert;
	logic [31:0] idle_limit;
	logic [7:0] fx_seen = 8'h00;
	logic fx_clr = 1'b0;
	logic [31:0] q;
	logic e;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;

	lcs_status_bank #(.NUM_VC(NV), .NUM_LANES(NL)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .credit_at_min(credit_at_min),
		.credit_at_max(credit_at_max), .far_has_space(far_has_space),
		.input_full_write(input_full_write), .link_ev(link_ev), .lane_ev(lane_ev),
		.reset_fx(reset_fx), .scrambler_seed(scrambler_seed), .required_lanes(required_lanes),
		.lane_caps(lane_caps), .rx_invert(rx_invert), .idle_limit(idle_limit));

	always #2.5 pclk = ~pclk;

	// Reset effects are one-cycle pulses, so they are gathered rather than sampled at a guess
	always @(posedge pclk) begin
		fx_seen <= fx_clr ? 8'h00 : (fx_seen | reset_fx);
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches = mismatches + 1;
			final_report();
		end
	end

	task final_report;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			mismatches = mismatches + 1;
		end
	endtask

	// Request held until pready is sampled high; data and response taken at that edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n = n + 1;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			mismatches = mismatches + 1;
			final_report();
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	task lpulse(input lcs_pkg::lcs_link_ev_t v);
		@(posedge pclk);
		link_ev <= link_ev | v;
		@(posedge pclk);
		link_ev <= link_ev & ~v;
	endtask

	task bc(input logic [7:0] s);
		lcs_pkg::lcs_link_ev_t v;
		v = '0;
		v.bc_valid = 1'b1;
		v.bc_seq = s;
		lpulse(v);
	endtask

	task lnpulse(input int l, input lcs_pkg::lcs_lane_ev_t v);
		@(posedge pclk);
		lane_ev[l] <= lane_ev[l] | v;
		@(posedge pclk);
		lane_ev[l] <= lane_ev[l] & ~v;
	endtask

	task fx_run(input logic [31:0] ctrl, input logic [7:0] exp);
		@(posedge pclk);
		fx_clr <= 1'b1;
		@(posedge pclk);
		fx_clr <= 1'b0;
		wr(lcs_pkg::ADDR_CONTROL, ctrl);
		repeat (3) @(posedge pclk);
		check({24'h0, fx_seen}, {24'h0, exp});
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(lcs_pkg::ADDR_CONFIG, 32'h00000001);
		rd_chk(lcs_pkg::ADDR_SEED, 32'hffffffff);
		rd_chk(lcs_pkg::ADDR_IDLE_LIMIT, 32'h00030d40);
		rd_chk(lcs_pkg::ADDR_RETRY_COUNT, 32'h00000000);
		check(scrambler_seed, 32'hffffffff);
		apb(1'b0, 12'h024, 32'h0);
		check({31'h0, e}, 32'h00000001);
		check(q, 32'h00000000);
		wr(lcs_pkg::ADDR_CONFIG, 32'h00002a03);
		wr(lcs_pkg::ADDR_SEED, 32'h12345678);
		wr(lcs_pkg::ADDR_IDLE_LIMIT, 32'h00000004);
		rd_chk(lcs_pkg::ADDR_CONFIG, 32'h00002a03);
		check({lane_caps, required_lanes, scrambler_seed[15:0]}, 32'h2a035678);
		check(idle_limit, 32'h00000004);
		// Buffer flags: overuse, overflow, underuse, credit level
		@(posedge pclk);
		far_has_space <= 8'h81;
		credit_at_min <= 8'h04;
		input_full_write <= 8'h20;
		@(posedge pclk);
		credit_at_min <= 8'h00;
		input_full_write <= 8'h00;
		credit_at_max <= 8'h02;
		repeat (10) @(posedge pclk);
		credit_at_max <= 8'h08;
		repeat (2) @(posedge pclk);
		credit_at_max <= 8'h00;
		rd_chk(lcs_pkg::ADDR_VC_STATUS, 32'h81022004);
		rd_chk(lcs_pkg::ADDR_VC_STATUS, 32'h81022004);
		wr(lcs_pkg::ADDR_VC_STATUS, 32'h00022004);
		rd_chk(lcs_pkg::ADDR_VC_STATUS, 32'h81000000);
		// Broadcast sequence, including a wrap past 255
		bc(8'h0a);
		bc(8'h0b);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h00000000);
		bc(8'h0d);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h00000001);
		wr(lcs_pkg::ADDR_LINK_STATUS, 32'h00000001);
		bc(8'hfe);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h00000002);
		wr(lcs_pkg::ADDR_LINK_STATUS, 32'h00000002);
		bc(8'hff);
		bc(8'h01);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h00000001);
		wr(lcs_pkg::ADDR_LINK_STATUS, 32'h0000003f);
		// Retry layer and serial flags; crc16 with bit sync, then each short-check cause
		link_ev.retry_empty <= 1'b1;
		lpulse(15'h0021);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h00000034);
		lpulse(15'h0010);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h0000003c);
		wr(lcs_pkg::ADDR_LINK_STATUS, 32'h00000008);
		lpulse(15'h0008);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h0000003c);
		link_ev.retry_empty <= 1'b0;
		wr(lcs_pkg::ADDR_LINK_STATUS, 32'h0000003f);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h00000000);
		// Lanes: an inactive lane must not report signal loss
		lane_ev[1].active <= 1'b1;
		lnpulse(2, 9'h080);
		lnpulse(1, 9'h0e0);
		lnpulse(3, 9'h01e);
		lnpulse(0, 9'h001);
		rd_chk(lcs_pkg::ADDR_LANE_STATUS, 32'hf0000f00);
		rd_chk(lcs_pkg::ADDR_LANE_CTRL, 32'h00000100);
		wr(lcs_pkg::ADDR_LANE_STATUS, 32'hf0000f00);
		rd_chk(lcs_pkg::ADDR_LANE_STATUS, 32'h00000100);
		// Retry counter, cleared by remote flush and by warm reset
		repeat (3) lpulse(15'h0002);
		rd_chk(lcs_pkg::ADDR_RETRY_COUNT, 32'h00000003);
		lnpulse(0, 9'h002);
		rd_chk(lcs_pkg::ADDR_RETRY_COUNT, 32'h00000000);
		repeat (2) lpulse(15'h0002);
		wr(lcs_pkg::ADDR_LANE_CTRL, 32'h0000010f);
		rd_chk(lcs_pkg::ADDR_LANE_CTRL, 32'h0000000f);
		fx_run(32'h00000002, 8'h03);
		rd_chk(lcs_pkg::ADDR_RETRY_COUNT, 32'h00000000);
		rd_chk(lcs_pkg::ADDR_SEED, 32'h12345678);
		rd_chk(lcs_pkg::ADDR_CONFIG, 32'h00002a03);
		rd_chk(lcs_pkg::ADDR_LANE_CTRL, 32'h00000000);
		check({28'h0, rx_invert}, 32'h00000000);
		// Cold reset: seed, config and retry count back, and the next broadcast is only recorded
		lpulse(15'h0002);
		fx_run(32'h00000001, 8'hff);
		rd_chk(lcs_pkg::ADDR_SEED, 32'hffffffff);
		rd_chk(lcs_pkg::ADDR_CONFIG, 32'h00000001);
		rd_chk(lcs_pkg::ADDR_RETRY_COUNT, 32'h00000000);
		bc(8'h50);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h00000000);
		bc(8'h52);
		rd_chk(lcs_pkg::ADDR_LINK_STATUS, 32'h00000001);
		final_report();
	end
endmodule // lcs_status_bank_bench
`default_nettype wire
